//--- dv/spw_port_monitor.sv
// Concurrent checks on the supervisor bus port, bound to every instance of it.
`timescale 1ns/1ps
module spw_port_monitor
    import spw_pkg::*;
#(
    parameter int HOLD_CNT = HOLD_CYCLES
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              chip_enable_n,
    input wire logic              write_enable_n,
    input wire logic              output_enable_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              data_oe,
    input wire logic              power_fail_threshold,
    input wire logic              battery_backup,
    input wire logic              sram_chip_enable_n,
    input wire logic              sram_output_enable_n,
    input wire logic              sram_chip_enable_oe,
    input wire logic              sram_output_enable_oe,
    input wire logic              reset_out,
    input wire logic              reg_write_pulse
);
    logic [5:0] good_r;
    // Counts good supply on the raw pins; the port sees it later, so the hold check is safe.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst || power_fail_threshold || battery_backup) begin
            good_r <= 6'h00;
        end else if (good_r != 6'h3F) begin
            good_r <= good_r + 6'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_fail_ce; power_fail_threshold [*5] |-> sram_chip_enable_n; endproperty
    a_fail_ce: assert property (p_fail_ce)
        else $error("sram enable low during power fail");
    property p_fail_rst; power_fail_threshold [*5] |-> reset_out; endproperty
    a_fail_rst: assert property (p_fail_rst)
        else $error("reset output low during power fail");
    property p_fail_wr; power_fail_threshold [*5] |-> !reg_write_pulse; endproperty
    a_fail_wr: assert property (p_fail_wr)
        else $error("register written during power fail");
    property p_hold;
        good_r != 6'h00 && good_r <= HOLD_CNT |-> reset_out && sram_chip_enable_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("protection released before hold ended");
    property p_release; good_r == 6'h28 && HOLD_CNT < 20 |-> !reset_out; endproperty
    a_release: assert property (p_release)
        else $error("reset output stuck after hold");
    property p_we_off; !write_enable_n |=> !data_oe; endproperty
    a_we_off: assert property (p_we_off)
        else $error("data driven after write enable fell");
    property p_both_fall;
        $fell(chip_enable_n) && $fell(write_enable_n) |-> !data_oe [*5];
    endproperty
    a_both_fall: assert property (p_both_fall)
        else $error("data driven in write cycle");
    property p_rd_drv;
        (!chip_enable_n && write_enable_n && !output_enable_n && addr >= REG_BASE
         && !reset_out && !power_fail_threshold) [*5] |-> data_oe;
    endproperty
    a_rd_drv: assert property (p_rd_drv)
        else $error("register read not driven");
    property p_rd_goe;
        (!chip_enable_n && write_enable_n && addr >= REG_BASE) [*5] |-> sram_output_enable_n;
    endproperty
    a_rd_goe: assert property (p_rd_goe)
        else $error("sram output enable active on register read");
    property p_bb;
        battery_backup [*4] |-> !data_oe && sram_chip_enable_oe && sram_output_enable_oe;
    endproperty
    a_bb: assert property (p_bb)
        else $error("wrong output drive in battery backup");
endmodule

bind spw_port spw_port_monitor #(.HOLD_CNT(HOLD_CNT)) u_mon (.clk_sys, .rst, .chip_enable_n,
    .write_enable_n, .output_enable_n, .addr, .data_oe, .power_fail_threshold, .battery_backup,
    .sram_chip_enable_n, .sram_output_enable_n, .sram_chip_enable_oe, .sram_output_enable_oe,
    .reset_out, .reg_write_pulse);

//--- dv/spw_port_tb.sv
// Self-checking bench for the supervisor bus port with an SRAM model.
`timescale 1ns/1ps
module spw_port_tb;
    import spw_pkg::*;
    logic clk_sys, rst, chip_enable_n, write_enable_n, output_enable_n, irq_freq_test_in;
    logic power_fail_threshold, battery_backup, data_oe, sram_chip_enable_n;
    logic sram_output_enable_n, sram_chip_enable_oe, sram_output_enable_oe, reset_out;
    logic irq_freq_test_out, sram_supply_out, reg_write_pulse, dq_oe;
    logic [ADDR_W-1:0] addr, a;
    logic [DATA_W-1:0] data_in, data_out, dq, d;
    logic [DATA_W-1:0] exp_reg [16];
    logic [3:0] reg_write_idx, last_idx;
    int err_count, n_checks, pulses, np, seed;
    spw_port #(.HOLD_CNT(10)) DUT (.clk_sys, .rst, .ce(1'b1), .chip_enable_n, .write_enable_n,
        .output_enable_n, .addr, .data_in, .data_out, .data_oe, .power_fail_threshold,
        .battery_backup, .irq_freq_test_in, .sram_chip_enable_n, .sram_output_enable_n,
        .sram_chip_enable_oe, .sram_output_enable_oe, .reset_out, .irq_freq_test_out,
        .sram_supply_out, .reg_write_pulse, .reg_write_idx);
    spw_sram SRAM (.clk_sys, .sram_chip_enable_n, .sram_output_enable_n, .write_enable_n,
        .addr, .data_in, .dq, .dq_oe);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (reg_write_pulse === 1'b1) begin
        pulses++;
        last_idx = reg_write_idx;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %0h got %0h", nm, e, s);
        end
    endtask
    // Register index that a write to a given address must report.
    function automatic logic [3:0] exp_idx(logic [18:0] wa);
        return 4'(wa - REG_BASE);
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Both strobes fall together; the write is closed by one of them first.
    task automatic wr(logic [18:0] wa, logic [7:0] wd, bit ce_first);
        addr = wa;
        data_in = wd;
        output_enable_n = 1'b1;
        {chip_enable_n, write_enable_n} = 2'b00;
        cyc(5);
        if (ce_first) chip_enable_n = 1'b1;
        else write_enable_n = 1'b1;
        cyc(1);
        {chip_enable_n, write_enable_n} = 2'b11;
        cyc(7);
    endtask
    task automatic rd(logic [18:0] ra);
        addr = ra;
        {chip_enable_n, output_enable_n} = 2'b00;
        cyc(6);
    endtask
    task automatic idle;
        {chip_enable_n, output_enable_n} = 2'b11;
        cyc(2);
    endtask
    task automatic wait_up;
        int i;
        for (i = 0; i < 100 && reset_out !== 1'b0; i++) cyc(1);
        chk("reset_out", 0, reset_out);
        if (i == 100) complete_run;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        complete_run;
    end
    initial begin
        seed = 32'he21bae87;
        {chip_enable_n, write_enable_n, output_enable_n} = 3'b111;
        {power_fail_threshold, battery_backup, irq_freq_test_in, rst} = 4'h1;
        addr = '0;
        data_in = '0;
        {err_count, n_checks, pulses, np} = '0;
        cyc(2);
        rst = 1'b0;
        cyc(8);
        chk("reset_out", 1, reset_out);
        chk("sram_ce_n", 1, sram_chip_enable_n);
        wait_up;
        chk("supervisor outs", 2'b10, {sram_supply_out, irq_freq_test_out});
        for (int i = 0; i < 16; i++) begin
            exp_reg[i] = 8'($random(seed));
            wr(REG_BASE + 19'(i), exp_reg[i], i[0]);
            np++;
            chk("reg_write_idx", exp_idx(REG_BASE + 19'(i)), last_idx);
            chk("pulses", np, pulses);
        end
        for (int i = 0; i < 16; i++) begin
            rd(REG_BASE + 19'(i));
            chk("data_out", exp_reg[i], data_out);
            chk("sram_oe_n", 1, sram_output_enable_n);
            idle;
        end
        rd(REG_BASE + 19'h3);
        data_in = exp_reg[3];
        write_enable_n = 1'b0;
        cyc(2);
        chk("data_oe", 0, data_oe);
        write_enable_n = 1'b1;
        idle;
        cyc(5);
        np++;
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 19'h7FFEF : 19'($random(seed)) & 19'h3FFFF;
            d = 8'($random(seed));
            wr(a, d, i[0]);
            chk("pulses", np, pulses);
            rd(a);
            chk("sram dq", {1'b1, d}, {dq_oe, dq});
            chk("oe pair", 2'b00, {data_oe, sram_output_enable_n});
            idle;
        end
        {power_fail_threshold, irq_freq_test_in} = 2'b11;
        cyc(5);
        chk("reset_out", 1, reset_out);
        chk("sram_ce_n", 1, sram_chip_enable_n);
        wr(REG_BASE + 19'h5, ~exp_reg[5], 1'b0);
        wr(a, ~d, 1'b1);
        chk("pulses", np, pulses);
        battery_backup = 1'b1;
        cyc(5);
        chk("out drive", 3'b110, {sram_chip_enable_oe, sram_output_enable_oe, data_oe});
        chk("supervisor outs", 2'b11, {sram_supply_out, irq_freq_test_out});
        {battery_backup, power_fail_threshold} = 2'b00;
        cyc(8);
        chk("reset_out", 1, reset_out);
        chk("sram_ce_n", 1, sram_chip_enable_n);
        wait_up;
        rd(REG_BASE + 19'h5);
        chk("data_out", exp_reg[5], data_out);
        idle;
        rd(a);
        chk("sram dq", d, dq);
        idle;
        complete_run;
    end
endmodule

//--- dv/spw_sram.sv
// Behavioural external SRAM behind the gated enables.
`timescale 1ns/1ps
module spw_sram
    import spw_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              sram_chip_enable_n,
    input  wire logic              sram_output_enable_n,
    input  wire logic              write_enable_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] dq,
    output logic                   dq_oe
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    initial begin
        dq = 8'h00;
        dq_oe = 1'b0;
    end
    // Only the gated enable qualifies a write, so a forced-high enable protects the array.
    always @(posedge clk_sys) begin
        if (!sram_chip_enable_n && !write_enable_n) mem[addr] = data_in;
        dq_oe <= !sram_chip_enable_n && !sram_output_enable_n;
        // A released bus inverts its value every cycle, so it alternates between its last value and that value's inverse.
        if (!sram_chip_enable_n && !sram_output_enable_n) dq <= mem[addr];
        else dq <= ~dq;
    end
endmodule

//--- hdl/spw_pkg.sv
// Package with constants and types for the supervisor bus port.
package spw_pkg;
    localparam int          ADDR_W          = 19;
    localparam int          DATA_W          = 8;
    localparam int          REG_NUM         = 16;
    // Internal registers occupy the top sixteen byte addresses, from 7FFF0h upward.
    localparam logic [18:0] REG_BASE        = 19'h7FFF0;
    localparam int          REG_IDX_LSB     = 0;
    localparam int          REG_IDX_W       = 4;
    localparam logic [7:0]  REG_RST_VAL     = 8'h00;
    localparam int          HOLD_TIME_MS    = 200;
    localparam int          CLK_MHZ         = 100;
    localparam int          HOLD_CYCLES     = HOLD_TIME_MS * 1000 * CLK_MHZ;
    localparam int          SYNC_STAGES     = 2;

    typedef enum logic [1:0] {
        SPW_PWR_OFF  = 2'b00,
        SPW_PWR_HOLD = 2'b01,
        SPW_PWR_ON   = 2'b11
    } spw_pwr_t;
endpackage

//--- hdl/spw_port.sv
// Bus port of the supervisor: write framing, decode, output control, power-fail gating.
`timescale 1ns/1ps
module spw_port
    import spw_pkg::*;
#(
    parameter int HOLD_CNT = HOLD_CYCLES
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire logic                         chip_enable_n,
    input  wire logic                         write_enable_n,
    input  wire logic                         output_enable_n,
    input  wire logic [spw_pkg::ADDR_W-1:0]   addr,
    input  wire logic [spw_pkg::DATA_W-1:0]   data_in,
    output logic      [spw_pkg::DATA_W-1:0]   data_out,
    output logic                              data_oe,
    input  wire logic                         power_fail_threshold,
    input  wire logic                         battery_backup,
    input  wire logic                         irq_freq_test_in,
    output logic                              sram_chip_enable_n,
    output logic                              sram_output_enable_n,
    output logic                              sram_chip_enable_oe,
    output logic                              sram_output_enable_oe,
    output logic                              reset_out,
    output logic                              irq_freq_test_out,
    output logic                              sram_supply_out,
    output logic                              reg_write_pulse,
    output logic      [spw_pkg::REG_IDX_W-1:0] reg_write_idx
);
    import spw_pkg::*;

    localparam int CNT_W = $clog2(HOLD_CNT + 1);

    // Strobe and supply pins pass two flip-flops; only the raw write-enable is also read directly.
    logic [4:0] pins_s;
    logic       ce_n_s;
    logic       we_n_s;
    logic       oe_n_s;
    logic       pfail_s;
    logic       batt_s;

    spw_sync #(
        .W       (5),
        .RST_VAL (5'h1F)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .d       ({chip_enable_n, write_enable_n, output_enable_n,
                   power_fail_threshold, battery_backup}),
        .q       (pins_s)
    );

    assign ce_n_s  = pins_s[4];
    assign we_n_s  = pins_s[3];
    assign oe_n_s  = pins_s[2];
    assign pfail_s = pins_s[1];
    assign batt_s  = pins_s[0];

    // Address and data pass two flip-flops like the strobes, so the decode stays in
    // step with the synchronised strobes; the host holds both steady through a cycle.
    logic [ADDR_W-1:0] addr_m_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] din_m_r;
    logic [DATA_W-1:0] din_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_m_r <= '0;
            addr_r   <= '0;
        end else if (ce) begin
            addr_m_r <= addr;
            addr_r   <= addr_m_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            din_m_r <= '0;
            din_r   <= '0;
        end else if (ce) begin
            din_m_r <= data_in;
            din_r   <= din_m_r;
        end
    end

    // Power sequencing state and the post-power-up hold counter.
    spw_pwr_t           pwr_r;
    spw_pwr_t           pwr_nxt;
    logic [CNT_W-1:0]   hold_cnt_r;

    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            SPW_PWR_OFF: begin
                if (!pfail_s) begin
                    pwr_nxt = SPW_PWR_HOLD;
                end
            end
            SPW_PWR_HOLD: begin
                if (pfail_s) begin
                    pwr_nxt = SPW_PWR_OFF;
                end else if (hold_cnt_r == CNT_W'(HOLD_CNT - 1)) begin
                    pwr_nxt = SPW_PWR_ON;
                end
            end
            SPW_PWR_ON: begin
                if (pfail_s) begin
                    pwr_nxt = SPW_PWR_OFF;
                end
            end
            default: pwr_nxt = SPW_PWR_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwr_r <= SPW_PWR_OFF;
        end else if (ce) begin
            pwr_r <= pwr_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= '0;
        end else if (ce) begin
            if (pwr_r == SPW_PWR_HOLD && !pfail_s) begin
                hold_cnt_r <= hold_cnt_r + CNT_W'(1);
            end else begin
                hold_cnt_r <= '0;
            end
        end
    end

    logic powered;
    assign powered = (pwr_r == SPW_PWR_ON) && !pfail_s;

    // Internal chip-enable is gated off whenever the supply is not good.
    logic int_ce;
    assign int_ce = powered && !ce_n_s;

    // Address decode.
    logic is_reg;
    assign is_reg = (addr_r >= REG_BASE);

    // Write framing: the write is open only while both strobes are low.
    logic wr_act;
    logic wr_act_d_r;
    assign wr_act = int_ce && !we_n_s;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_act_d_r <= 1'b0;
        end else if (ce) begin
            wr_act_d_r <= wr_act;
        end
    end

    // Register file; the data is committed at the end of the write so the last stable
    // data is stored, and an abort by power fail commits nothing.
    logic [DATA_W-1:0] regs_r [REG_NUM];
    logic [DATA_W-1:0] wr_data_r;
    logic              wr_is_reg_r;
    logic [REG_IDX_W-1:0] wr_idx_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_data_r   <= '0;
            wr_is_reg_r <= 1'b0;
            wr_idx_r    <= '0;
        end else if (ce && wr_act) begin
            wr_data_r   <= din_r;
            wr_is_reg_r <= is_reg;
            wr_idx_r    <= addr_r[REG_IDX_LSB +: REG_IDX_W];
        end
    end

    logic wr_end;
    assign wr_end = wr_act_d_r && !wr_act && powered;

    genvar gi;
    generate
        for (gi = 0; gi < REG_NUM; gi++) begin : g_reg
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    regs_r[gi] <= REG_RST_VAL;
                end else if (ce && wr_end && wr_is_reg_r &&
                             wr_idx_r == REG_IDX_W'(gi)) begin
                    regs_r[gi] <= wr_data_r;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_write_pulse <= 1'b0;
        end else if (ce) begin
            reg_write_pulse <= wr_end && wr_is_reg_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_write_idx <= '0;
        end else if (ce) begin
            reg_write_idx <= wr_idx_r;
        end
    end

    // The raw pin is read here as well, so the drivers close in the cycle that
    // write-enable falls rather than two synchroniser stages later. This path can
    // only close the drivers, so a bad sample costs at most one cycle of drive.
    logic we_n;
    assign we_n = write_enable_n;

    // Read decode. The drive also needs the raw write-enable high, so enables that
    // fall together never open the drivers.
    logic                 rd_act;
    logic [REG_IDX_W-1:0] rd_idx;
    assign rd_act = int_ce && we_n_s;
    assign rd_idx = addr_r[REG_IDX_LSB +: REG_IDX_W];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_out <= '0;
        end else if (ce) begin
            data_out <= regs_r[rd_idx];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_oe <= 1'b0;
        end else if (ce) begin
            data_oe <= rd_act && is_reg && !oe_n_s && we_n &&
                       !batt_s;
        end
    end

    // The SRAM enables follow the gated internal chip-enable, which is high only in
    // the powered state, so power fail and the post-power-up hold both keep them high.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sram_chip_enable_n <= 1'b1;
        end else if (ce) begin
            sram_chip_enable_n <= !(int_ce && !is_reg);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sram_output_enable_n <= 1'b1;
        end else if (ce) begin
            sram_output_enable_n <= !(int_ce && !is_reg && !oe_n_s);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reset_out <= 1'b1;
        end else if (ce) begin
            reset_out <= (pwr_nxt != SPW_PWR_ON);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_freq_test_out <= 1'b0;
        end else if (ce) begin
            irq_freq_test_out <= irq_freq_test_in;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sram_supply_out <= 1'b0;
        end else if (ce) begin
            sram_supply_out <= 1'b1;
        end
    end

    // These pins keep driving in battery backup.
    assign sram_chip_enable_oe   = 1'b1;
    assign sram_output_enable_oe = 1'b1;
endmodule

//--- hdl/spw_sync.sv
// Two-stage synchroniser for a group of asynchronous input levels.
`timescale 1ns/1ps
module spw_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
